/* rtl/fpep_pkg.sv */
package fpep_pkg;
  // register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NUM_BLOCKS = 8;
  localparam int FETCH_W = 20;

  // register offsets
  localparam logic [3:0] OFS_FLASH_CTRL = 4'h0;
  localparam logic [3:0] OFS_ERASE_BLK = 4'h1;
  localparam logic [3:0] OFS_FLASH_STAT = 4'h2;
  localparam logic [3:0] OFS_RAM_CTRL = 4'h3;

  // flash_ctrl_reg fields
  localparam int CTRL_WR_EN = 7;
  localparam int CTRL_ERASE_SETUP = 6;
  localparam int CTRL_PROG_SETUP = 5;
  localparam int CTRL_ERASE_VFY = 4;
  localparam int CTRL_PROG_VFY = 3;
  localparam int CTRL_E = 1;
  localparam int CTRL_P = 0;
  localparam logic [7:0] CTRL_WMASK = 8'hfb;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // erase_block_select
  localparam logic [7:0] EBLK_RST = 8'h00;

  // ram_ctrl_reg fields
  localparam int RAMC_SEL = 3;
  localparam int RAMC_AREA_LSB = 1;
  localparam int RAMC_AREA_W = 2;
  localparam logic [7:0] RAMC_WMASK = 8'h0e;
  localparam logic [7:0] RAMC_RST = 8'h00;

  // flash_status_reg fields
  localparam int STAT_ERR = 7;
  localparam int STAT_EVFY = 3;
  localparam int STAT_PVFY = 2;
  localparam int STAT_ERASE = 1;
  localparam int STAT_PROG = 0;

  // boot program area in on-chip ram
  localparam logic [19:0] BOOT_RAM_LO = 20'hfef10;
  localparam logic [19:0] BOOT_RAM_HI = 20'hff2ff;

  // timing
  localparam int SYS_CLK_HZ = 25000000;
  localparam int RESET_MIN_CYC = 20;

  typedef enum logic [2:0] {
    fpep_idle = 3'b000,
    fpep_psetup = 3'b001,
    fpep_prog = 3'b010,
    fpep_pvfy = 3'b011,
    fpep_esetup = 3'b100,
    fpep_erase = 3'b101,
    fpep_evfy = 3'b110
  } fpep_mode_t;
endpackage

/* rtl/fpep_sync.sv */
`timescale 1ns/1ps
module fpep_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // asynchronous levels in, synchronous levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= '0;
      sync_out <= '0;
    end else begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule

/* rtl/fpep_protect.sv */
// Chosen here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
// Overview of operation
// - write-enable pin low clears control and block registers, blocks all modes.
// - any reset or standby clears both registers and blocks all modes.
// - on error, registers kept but program or erase aborts at once.
// - with error set, program/erase bits writable but no mode entry.
// - with error set, verify bits still enter verify modes.
// - error cleared only by pin reset, watchdog reset, hardware standby.
// - software standby in error state clears both registers.
// - write-enable pin low removes the ram overlay.
// - hardware or error protection makes every block unerasable.
// - overlay select blocks program/erase everywhere, verify still allowed.
// - erase only in selected blocks; selection does not affect programming.
// - block select of zero protects every block from erase.
// - error flag set only by its defined detection condition.
// - program or erase bit set blocks the nmi input.
// - boot mode blocks nmi until fetch reaches boot ram area.
// - after that branch nmi accepted except during program/erase.
// - nmi also blocked in error state and held bits during emulation.
// - modes entered through setup, program, erase and verify bits.
// - no program or erase while software write enable is zero.
module fpep_protect (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // pins
  input wire logic flash_write_enable_pin,
  input wire logic nmi_pin,
  // system events
  input wire logic watchdog_reset_req,
  input wire logic sw_standby,
  input wire logic hw_standby,
  input wire logic fault_detect,
  input wire logic boot_mode,
  input wire logic [19:0] fetch_addr,
  input wire logic fetch_valid,
  // flash mode outputs
  output logic program_mode,
  output logic erase_mode,
  output logic program_verify_mode,
  output logic erase_verify_mode,
  output logic [7:0] erase_block_ok,
  // overlay and status
  output logic overlay_active,
  output logic [1:0] overlay_area,
  output logic flash_error_flag,
  output logic nmi_req
);
  logic pin_wr_en_s;
  logic nmi_s;
  logic [7:0] flash_ctrl_reg_r;
  logic [7:0] erase_block_select_r;
  logic [7:0] ram_ctrl_reg_r;
  logic err_r;
  logic boot_lock_r;
  logic [7:0] rdata_r;
  logic nmi_req_r;
  logic [7:0] blk_ok_r;
  fpep_pkg::fpep_mode_t mode_r;
  fpep_pkg::fpep_mode_t mode_nxt;

  logic hw_prot;
  logic init_regs;
  logic err_clr;
  logic err_set;
  logic err_prot;
  logic sw_wr_en;
  logic ram_sel;
  logic pe_ok;
  logic vfy_ok;
  logic pe_held;
  logic boot_hit;
  logic nmi_block;
  logic [7:0] blk_ok;
  logic [7:0] stat_val;

  fpep_sync #(.W(2)) u_sync (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .async_in({flash_write_enable_pin, nmi_pin}),
    .sync_out({pin_wr_en_s, nmi_s})
  );

  assign sw_wr_en = flash_ctrl_reg_r[fpep_pkg::CTRL_WR_EN];
  assign ram_sel = ram_ctrl_reg_r[fpep_pkg::RAMC_SEL];
  assign pe_held = flash_ctrl_reg_r[fpep_pkg::CTRL_P] | flash_ctrl_reg_r[fpep_pkg::CTRL_E];

  // hardware protection sources
  assign hw_prot = ~pin_wr_en_s | watchdog_reset_req | sw_standby | hw_standby;
  assign init_regs = hw_prot;
  assign err_clr = watchdog_reset_req | hw_standby;
  // error only from fault detection while program/erase bits are held
  assign err_set = fault_detect & pe_held & pin_wr_en_s;
  assign err_prot = err_r | err_set;

  // all protection evaluated together each clock
  assign pe_ok = ~hw_prot & ~err_prot & ~ram_sel & sw_wr_en;
  assign vfy_ok = ~hw_prot & sw_wr_en;

  genvar gi;
  generate
    for (gi = 0; gi < fpep_pkg::NUM_BLOCKS; gi++) begin : g_blk
      // zero select leaves every block protected
      assign blk_ok[gi] = pe_ok & erase_block_select_r[gi];
    end
  endgenerate

  // mode selection from control bits
  always_comb begin
    mode_nxt = fpep_pkg::fpep_idle;
    if (!vfy_ok) begin
      mode_nxt = fpep_pkg::fpep_idle;
    end else if (flash_ctrl_reg_r[fpep_pkg::CTRL_P]
                 && flash_ctrl_reg_r[fpep_pkg::CTRL_PROG_SETUP] && pe_ok) begin
      mode_nxt = fpep_pkg::fpep_prog;
    end else if (flash_ctrl_reg_r[fpep_pkg::CTRL_E]
                 && flash_ctrl_reg_r[fpep_pkg::CTRL_ERASE_SETUP] && (|blk_ok)) begin
      mode_nxt = fpep_pkg::fpep_erase;
    end else if (flash_ctrl_reg_r[fpep_pkg::CTRL_PROG_VFY]) begin
      mode_nxt = fpep_pkg::fpep_pvfy;
    end else if (flash_ctrl_reg_r[fpep_pkg::CTRL_ERASE_VFY]) begin
      mode_nxt = fpep_pkg::fpep_evfy;
    end else if (flash_ctrl_reg_r[fpep_pkg::CTRL_PROG_SETUP]) begin
      mode_nxt = fpep_pkg::fpep_psetup;
    end else if (flash_ctrl_reg_r[fpep_pkg::CTRL_ERASE_SETUP]) begin
      mode_nxt = fpep_pkg::fpep_esetup;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= fpep_pkg::fpep_idle;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      blk_ok_r <= 8'h00;
    end else begin
      blk_ok_r <= blk_ok;
    end
  end

  // flash control register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_ctrl_reg_r <= fpep_pkg::CTRL_RST;
    end else if (init_regs) begin
      flash_ctrl_reg_r <= fpep_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == fpep_pkg::OFS_FLASH_CTRL) begin
      // writes accepted even in error state
      flash_ctrl_reg_r <= reg_wdata & fpep_pkg::CTRL_WMASK;
    end
  end

  // erase block select register
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      erase_block_select_r <= fpep_pkg::EBLK_RST;
    end else if (init_regs) begin
      erase_block_select_r <= fpep_pkg::EBLK_RST;
    end else if (reg_wr && reg_addr == fpep_pkg::OFS_ERASE_BLK) begin
      erase_block_select_r <= reg_wdata;
    end
  end

  // ram control register, overlay dropped while the pin is low
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ram_ctrl_reg_r <= fpep_pkg::RAMC_RST;
    end else if (!pin_wr_en_s) begin
      ram_ctrl_reg_r <= fpep_pkg::RAMC_RST;
    end else if (reg_wr && reg_addr == fpep_pkg::OFS_RAM_CTRL) begin
      ram_ctrl_reg_r <= reg_wdata & fpep_pkg::RAMC_WMASK;
    end
  end

  // sticky error flag, set wins over clear, no register write clears it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      err_r <= 1'b0;
    end else if (err_set) begin
      err_r <= 1'b1;
    end else if (err_clr) begin
      err_r <= 1'b0;
    end
  end

  // boot mode nmi lock, released by fetch from boot ram area
  assign boot_hit = fetch_valid && fetch_addr >= fpep_pkg::BOOT_RAM_LO
                    && fetch_addr <= fpep_pkg::BOOT_RAM_HI;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      boot_lock_r <= 1'b1;
    end else if (watchdog_reset_req) begin
      boot_lock_r <= 1'b1;
    end else if (boot_hit) begin
      boot_lock_r <= 1'b0;
    end
  end

  assign nmi_block = pe_held | err_r | (boot_mode & boot_lock_r);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      nmi_req_r <= 1'b0;
    end else begin
      nmi_req_r <= nmi_s & ~nmi_block;
    end
  end

  // read port
  always_comb begin
    stat_val = 8'h00;
    stat_val[fpep_pkg::STAT_ERR] = err_r;
    stat_val[fpep_pkg::STAT_EVFY] = (mode_r == fpep_pkg::fpep_evfy);
    stat_val[fpep_pkg::STAT_PVFY] = (mode_r == fpep_pkg::fpep_pvfy);
    stat_val[fpep_pkg::STAT_ERASE] = (mode_r == fpep_pkg::fpep_erase);
    stat_val[fpep_pkg::STAT_PROG] = (mode_r == fpep_pkg::fpep_prog);
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        fpep_pkg::OFS_FLASH_CTRL: begin
          rdata_r <= flash_ctrl_reg_r;
        end
        fpep_pkg::OFS_ERASE_BLK: begin
          rdata_r <= erase_block_select_r;
        end
        fpep_pkg::OFS_FLASH_STAT: begin
          rdata_r <= stat_val;
        end
        fpep_pkg::OFS_RAM_CTRL: begin
          rdata_r <= ram_ctrl_reg_r;
        end
        default: begin
          rdata_r <= 8'h00;
        end
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // outputs
  assign reg_rdata = rdata_r;
  assign program_mode = (mode_r == fpep_pkg::fpep_prog);
  assign erase_mode = (mode_r == fpep_pkg::fpep_erase);
  assign program_verify_mode = (mode_r == fpep_pkg::fpep_pvfy);
  assign erase_verify_mode = (mode_r == fpep_pkg::fpep_evfy);
  assign erase_block_ok = blk_ok_r;
  assign overlay_active = ram_ctrl_reg_r[fpep_pkg::RAMC_SEL];
  assign overlay_area = ram_ctrl_reg_r[fpep_pkg::RAMC_AREA_LSB +: fpep_pkg::RAMC_AREA_W];
  assign flash_error_flag = err_r;
  assign nmi_req = nmi_req_r;

  // checks
  a_pin_low_init: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pin_wr_en_s |=> flash_ctrl_reg_r == 8'h00 && erase_block_select_r == 8'h00 && !program_mode
    && !erase_mode && !program_verify_mode && !erase_verify_mode)
    else $error("pin low did not clear registers");

  a_standby_init: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (watchdog_reset_req || sw_standby || hw_standby) |=> flash_ctrl_reg_r == 8'h00
    && erase_block_select_r == 8'h00 && mode_r == fpep_pkg::fpep_idle)
    else $error("reset or standby did not clear registers");

  a_err_abort: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (err_set && !reg_wr && !hw_prot) |=> !program_mode && !erase_mode
    && flash_ctrl_reg_r == $past(flash_ctrl_reg_r))
    else $error("error did not abort or lost register contents");

  a_err_no_pe: assert property (@(posedge clk_sys) disable iff (!rst_b)
    flash_error_flag |-> !program_mode && !erase_mode)
    else $error("program or erase mode in error state");

  a_err_verify: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (err_r && !hw_prot && sw_wr_en && flash_ctrl_reg_r[fpep_pkg::CTRL_PROG_VFY])
    |=> program_verify_mode)
    else $error("verify refused in error state");

  a_err_sticky: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (flash_error_flag && !watchdog_reset_req && !hw_standby) |=> flash_error_flag)
    else $error("error flag cleared without reset");

  a_overlay_drop: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pin_wr_en_s |=> !overlay_active)
    else $error("overlay kept with pin low");

  a_blk_lock: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (err_r || !pin_wr_en_s) |=> erase_block_ok == 8'h00)
    else $error("block erasable under protection");

  a_overlay_pe: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ram_sel |=> !program_mode && !erase_mode)
    else $error("program or erase with overlay selected");

  a_blk_sel_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    erase_block_select_r == 8'h00 |=> !erase_mode && erase_block_ok == 8'h00)
    else $error("erase with no block selected");

  a_nmi_pe_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pe_held |=> !nmi_req)
    else $error("nmi passed during program or erase");

  a_nmi_boot: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (boot_mode && boot_lock_r) |=> !nmi_req)
    else $error("nmi passed before boot branch");

  a_wr_en_off: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !sw_wr_en |=> !program_mode && !erase_mode)
    else $error("program or erase with software enable off");

  a_err_set_flag: assert property (@(posedge clk_sys) disable iff (!rst_b)
    err_set |=> flash_error_flag && !program_mode && !erase_mode)
    else $error("fault did not raise error and abort");

  a_blk_sel_only: assert property (@(posedge clk_sys) disable iff (!rst_b)
    erase_block_select_r != 8'h00 |=> (erase_block_ok & ~$past(erase_block_select_r)) == 8'h00)
    else $error("erase allowed in unselected block");

  a_nmi_err_block: assert property (@(posedge clk_sys) disable iff (!rst_b)
    err_r |=> !nmi_req)
    else $error("nmi passed in error state");

  a_nmi_open: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (nmi_s && !pe_held && !err_r && !(boot_mode && boot_lock_r)) |=> nmi_req)
    else $error("nmi dropped outside blocking states");
endmodule

/* verification/fpep_host_model.sv */
`timescale 1ns/1ps
module fpep_host_model (
  // clock
  input wire logic clk_sys,
  // pins toward the block
  output logic rst_b,
  output logic flash_write_enable_pin,
  output logic nmi_pin
);
  initial begin
    rst_b = 1'b0;
    flash_write_enable_pin = 1'b0;
    nmi_pin = 1'b0;
    // power-on hold, shortened to keep the run small
    repeat (4) @(posedge clk_sys);
    rst_b <= 1'b1;
  end

  // reset during operation, held the minimum length
  task automatic pulse_reset();
    @(posedge clk_sys);
    rst_b <= 1'b0;
    repeat (fpep_pkg::RESET_MIN_CYC) @(posedge clk_sys);
    rst_b <= 1'b1;
  endtask

  task automatic set_pins(input logic wr_en, input logic nmi);
    @(posedge clk_sys);
    flash_write_enable_pin <= wr_en;
    nmi_pin <= nmi;
  endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  localparam logic [3:0] A_C = fpep_pkg::OFS_FLASH_CTRL;
  localparam logic [3:0] A_E = fpep_pkg::OFS_ERASE_BLK;
  localparam logic [3:0] A_S = fpep_pkg::OFS_FLASH_STAT;
  localparam logic [3:0] A_R = fpep_pkg::OFS_RAM_CTRL;
  logic clk_sys = 1'b0;
  logic rst_b;
  logic wr_en_pin;
  logic nmi;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] ev = 4'h0;
  logic boot = 1'b0;
  logic fv = 1'b0;
  logic [19:0] fa = 20'h00000;
  logic [7:0] reg_rdata;
  logic [7:0] ebo;
  logic pm, em, pvm, evm, oa, ef, nreq;
  logic [1:0] oar;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] r;
  int err_count = 0;
  int n_compared = 0;

  always #20 clk_sys = ~clk_sys;

  fpep_host_model host (.clk_sys(clk_sys), .rst_b(rst_b), .flash_write_enable_pin(wr_en_pin),
    .nmi_pin(nmi));

  fpep_protect DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_write_enable_pin(wr_en_pin), .nmi_pin(nmi), .watchdog_reset_req(ev[1]),
    .sw_standby(ev[2]), .hw_standby(ev[3]), .fault_detect(ev[0]), .boot_mode(boot),
    .fetch_addr(fa), .fetch_valid(fv), .program_mode(pm), .erase_mode(em),
    .program_verify_mode(pvm), .erase_verify_mode(evm), .erase_block_ok(ebo),
    .overlay_active(oa), .overlay_area(oar), .flash_error_flag(ef), .nmi_req(nreq));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("compared=%0d errors=%0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
  endtask

  // one-cycle pulse on the event inputs
  task automatic pulse(input logic [3:0] m);
    @(posedge clk_sys);
    ev <= m;
    @(posedge clk_sys);
    ev <= 4'h0;
  endtask

  task automatic fetch(input logic [19:0] a);
    @(posedge clk_sys);
    fa <= a;
    fv <= 1'b1;
    @(posedge clk_sys);
    fv <= 1'b0;
  endtask

  // past synchroniser and mode register
  task automatic settle();
    repeat (4) @(posedge clk_sys);
    #1;
  endtask

  task automatic cm(input logic [7:0] e);
    chk({4'h0, pm, em, pvm, evm}, e);
  endtask

  always @(posedge clk_sys) rd_d <= reg_rd;

  always @(negedge clk_sys) begin
    if (rd_d) begin
      chk(reg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    results();
  end

  initial begin
    void'($urandom(45468));
    for (int i = 0; i < 10 && rst_b !== 1'b1; i++) @(posedge clk_sys);
    if (rst_b !== 1'b1) err_count++;
    rd(A_S, 8'h00);
    rd(4'h5, 8'h00);
    wr(A_C, 8'ha1);
    settle();
    rd(A_C, 8'h00);
    cm(8'h00);
    host.set_pins(1'b1, 1'b1);
    settle();
    wr(A_C, 8'ha1);
    settle();
    cm(8'h08);
    chk({7'h0, nreq}, 8'h00);
    rd(A_S, 8'h01);
    wr(A_C, 8'h21);
    settle();
    cm(8'h00);
    r = 8'($urandom_range(1, 255));
    wr(A_E, r);
    wr(A_C, 8'hc2);
    settle();
    cm(8'h04);
    chk(ebo, r);
    chk({7'h0, nreq}, 8'h00);
    wr(A_E, 8'h00);
    settle();
    cm(8'h00);
    chk(ebo, 8'h00);
    wr(A_C, 8'ha1);
    settle();
    cm(8'h08);
    wr(A_R, 8'h0a);
    settle();
    chk({5'h0, oa, oar}, 8'h05);
    cm(8'h00);
    wr(A_C, 8'h88);
    settle();
    cm(8'h02);
    wr(A_C, 8'h90);
    settle();
    cm(8'h01);
    host.set_pins(1'b0, 1'b1);
    settle();
    chk({7'h0, oa}, 8'h00);
    rd(A_C, 8'h00);
    host.set_pins(1'b1, 1'b1);
    settle();
    pulse(4'h1);
    settle();
    chk({7'h0, ef}, 8'h00);
    wr(A_C, 8'ha1);
    settle();
    pulse(4'h1);
    settle();
    chk({7'h0, ef}, 8'h01);
    cm(8'h00);
    rd(A_C, 8'ha1);
    wr(A_C, 8'h21);
    wr(A_C, 8'ha1);
    wr(A_E, r);
    settle();
    rd(A_C, 8'ha1);
    cm(8'h00);
    chk(ebo, 8'h00);
    chk({7'h0, nreq}, 8'h00);
    wr(A_C, 8'h88);
    settle();
    cm(8'h02);
    chk({7'h0, nreq}, 8'h00);
    wr(A_S, 8'h00);
    pulse(4'h4);
    settle();
    rd(A_C, 8'h00);
    rd(A_S, 8'h80);
    chk({7'h0, ef}, 8'h01);
    pulse(4'h8);
    settle();
    chk({7'h0, ef}, 8'h00);
    chk({7'h0, nreq}, 8'h01);
    wr(A_C, 8'ha1);
    settle();
    pulse(4'h1);
    settle();
    pulse(4'h2);
    settle();
    chk({7'h0, ef}, 8'h00);
    rd(A_C, 8'h00);
    wr(A_C, 8'ha1);
    settle();
    pulse(4'h1);
    host.pulse_reset();
    settle();
    chk({7'h0, ef}, 8'h00);
    rd(A_E, 8'h00);
    @(posedge clk_sys);
    boot <= 1'b1;
    settle();
    chk({7'h0, nreq}, 8'h00);
    fetch(fpep_pkg::BOOT_RAM_LO - 20'h00001);
    settle();
    chk({7'h0, nreq}, 8'h00);
    fetch(fpep_pkg::BOOT_RAM_LO + 20'($urandom_range(0, 20'h003ef)));
    settle();
    chk({7'h0, nreq}, 8'h01);
    wr(A_C, 8'ha1);
    settle();
    chk({7'h0, nreq}, 8'h00);
    results();
  end
endmodule
